// File: rtl/external_memory_bus_interface.sv
// External memory bus sequencer: address latch, strobes, stretch and on-chip data SRAM
`timescale 1ns/1ps
module external_memory_bus_interface
(
    // Clock and reset
    input  wire logic        i_core_clk,
    input  wire logic        i_rst,
    // Pins from outside
    input  wire logic        i_reset_pin,
    input  wire logic        i_external_fetch_force_n,
    input  wire logic        i_reboot_pin,
    input  wire logic [7:0]  i_addr_data,
    // Core request
    input  wire logic        i_req,
    input  wire logic [3:0]  i_op,
    input  wire logic [16:0] i_addr,
    input  wire logic [7:0]  i_wdata,
    // Software configuration
    input  wire logic [3:0]  i_stretch_mc,
    input  wire logic        i_onchip_xram_enable,
    input  wire logic        i_pullup_enable,
    input  wire logic [7:0]  i_port0_out,
    // Core answer
    output logic             o_busy,
    output logic             o_done,
    output logic [7:0]       o_rdata,
    output logic             o_internal_code,
    output logic             o_reset,
    output logic             o_reboot,
    // Bus pins
    output logic [7:0]       o_addr_data,
    output logic [7:0]       o_addr_data_oe,
    output logic             o_pullup_enable,
    output logic [7:0]       o_addr_high,
    output logic             o_addr_latch_strobe,
    output logic             o_program_read_strobe_n,
    output logic             o_data_read_strobe_n,
    output logic             o_data_write_strobe_n
);
    // Pin synchronisers
    logic [1:0] rst_sync;
    logic [1:0] ea_sync;
    logic [1:0] rb_sync;
    logic [7:0] ad_meta;
    logic [7:0] ad_sync;
    always_ff @(posedge i_core_clk or posedge i_rst)
        if (i_rst)
        begin
            rst_sync <= 2'h0;
            ea_sync  <= 2'h3;
            rb_sync  <= 2'h0;
            ad_meta  <= 8'h00;
            ad_sync  <= 8'h00;
        end
        else
        begin
            rst_sync <= {rst_sync[0], i_reset_pin};
            ea_sync  <= {ea_sync[0], i_external_fetch_force_n};
            rb_sync  <= {rb_sync[0], i_reboot_pin};
            ad_meta  <= i_addr_data;
            ad_sync  <= ad_meta;
        end

    // Reset only after the synchronised pin stays high for seven clocks
    logic [2:0] rst_cnt;
    always_ff @(posedge i_core_clk or posedge i_rst)
        if (i_rst)
            rst_cnt <= 3'h0;
        else if (!rst_sync[1])
            rst_cnt <= 3'h0;
        else if (rst_cnt != xbus_pkg::RST_HOLD_CLKS)
            rst_cnt <= rst_cnt + 3'h1;
    assign o_reset  = (rst_cnt == xbus_pkg::RST_HOLD_CLKS);
    assign o_reboot = rb_sync[1];
    wire soft_rst   = o_reset;

    // Machine cycle phase
    logic [1:0] phase;
    always_ff @(posedge i_core_clk or posedge i_rst)
        if (i_rst)
            phase <= 2'h0;
        else if (soft_rst)
            phase <= 2'h0;
        else
            phase <= phase + 2'h1;
    wire mc_end = (phase == xbus_pkg::PHASE_LAST);

    // Routing decode
    wire is_code   = (i_op == xbus_pkg::BUS_FETCH) || (i_op == xbus_pkg::BUS_TABLE);
    wire is_write  = (i_op == xbus_pkg::BUS_WRITE);
    wire code_int  = ea_sync[1] && (i_addr <= xbus_pkg::INT_CODE_TOP);
    wire xram_hit  = i_onchip_xram_enable && (i_addr[15:0] <= xbus_pkg::XRAM_TOP);
    wire go_int    = is_code ? code_int : xram_hit;
    wire [3:0] len = (i_stretch_mc < xbus_pkg::STRETCH_MIN) ? xbus_pkg::STRETCH_MIN :
                     (i_stretch_mc > xbus_pkg::STRETCH_MAX) ? xbus_pkg::STRETCH_MAX :
                     i_stretch_mc;
    assign o_internal_code = is_code && code_int;

    // On-chip data SRAM
    logic [7:0] xram [xbus_pkg::XRAM_DEPTH];
    always_ff @(posedge i_core_clk)
        if (i_req && !o_busy && !is_code && xram_hit && is_write && !soft_rst)
            xram[i_addr[9:0]] <= i_wdata;

    // Bus sequencer, advances on machine cycle boundaries except from ST_DONE, which lasts one clock
    xbus_pkg::bus_state_t state;
    xbus_pkg::bus_state_t next_state;
    logic [16:0] addr;
    logic [7:0]  wdata;
    logic        op_code;
    logic        op_write;
    logic [3:0]  mc_left;
    logic        int_done;

    // Busy covers the internal answer cycle, so a request still held then is not taken twice
    // External accesses start on a machine cycle boundary so the latch pulse gets both phases
    wire take_ext = i_req && !o_busy && !go_int && mc_end;

    always_comb
    begin
        next_state = state;
        unique case (state)
            xbus_pkg::ST_IDLE: if (take_ext) next_state = xbus_pkg::ST_ADDR;
            xbus_pkg::ST_ADDR: if (mc_end) next_state = xbus_pkg::ST_STRB;
            xbus_pkg::ST_STRB: if (mc_end) next_state = (mc_left > 4'h2) ? xbus_pkg::ST_HOLD
                                                                        : xbus_pkg::ST_DONE;
            xbus_pkg::ST_HOLD: if (mc_end && mc_left == 4'h3) next_state = xbus_pkg::ST_DONE;
            xbus_pkg::ST_DONE: next_state = xbus_pkg::ST_IDLE;
            default:           next_state = xbus_pkg::ST_IDLE;
        endcase
    end

    always_ff @(posedge i_core_clk or posedge i_rst)
        if (i_rst)
        begin
            state    <= xbus_pkg::ST_IDLE;
            addr     <= 17'h00000;
            wdata    <= 8'h00;
            op_code  <= 1'b0;
            op_write <= 1'b0;
            mc_left  <= 4'h0;
            o_rdata  <= 8'h00;
            int_done <= 1'b0;
        end
        else if (soft_rst)
        begin
            state    <= xbus_pkg::ST_IDLE;
            int_done <= 1'b0;
        end
        else
        begin
            state    <= next_state;
            int_done <= 1'b0;
            if (i_req && !o_busy)
            begin
                addr     <= i_addr;
                wdata    <= i_wdata;
                op_code  <= is_code;
                op_write <= is_write;
                mc_left  <= is_code ? xbus_pkg::STRETCH_MIN : len;
                int_done <= go_int;
                if (go_int && !is_code && !is_write)
                    o_rdata <= xram[i_addr[9:0]];
            end
            if (state == xbus_pkg::ST_HOLD && mc_end)
                mc_left <= mc_left - 4'h1;
            if (state != xbus_pkg::ST_IDLE && next_state == xbus_pkg::ST_DONE && !op_write)
                o_rdata <= ad_sync;
        end

    // Pin drive
    wire in_addr  = (state == xbus_pkg::ST_ADDR);
    wire in_strb  = (state == xbus_pkg::ST_STRB) || (state == xbus_pkg::ST_HOLD);
    wire ext_busy = in_addr || in_strb;
    assign o_busy  = (state != xbus_pkg::ST_IDLE) || int_done;
    assign o_done  = (state == xbus_pkg::ST_DONE) || int_done;
    // Latch pulse in first half of the address cycle; address stays valid past its fall
    assign o_addr_latch_strobe     = in_addr && !phase[1];
    assign o_program_read_strobe_n = !(in_strb && op_code);
    assign o_data_write_strobe_n   = !(in_strb && !op_code && op_write);
    assign o_data_read_strobe_n    = !(in_strb && !op_code && !op_write);
    assign o_addr_high             = ext_busy ? addr[15:8] : 8'h00;
    // Between accesses the low port is open drain: drive only the zeros
    assign o_addr_data    = in_addr ? addr[7:0] : (in_strb ? wdata : 8'h00);
    assign o_addr_data_oe = in_addr ? 8'hFF :
                            (in_strb && op_write && !op_code) ? 8'hFF :
                            ext_busy ? 8'h00 : ~i_port0_out;
    assign o_pullup_enable = i_pullup_enable;

    a_xram_reset_off : assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_req && !o_busy && !is_code && !i_onchip_xram_enable) |-> !go_int)
        else $error("data move went internal with sram disabled");
    a_no_int_strobe : assert property (@(posedge i_core_clk) disable iff (i_rst)
        (i_req && !o_busy && go_int) |=> o_program_read_strobe_n [*3])
        else $error("program read strobe on internal access");
    a_force_ext : assert property (@(posedge i_core_clk) disable iff (i_rst)
        (!ea_sync[1] && is_code) |-> !go_int)
        else $error("forced fetch served internally");
    sequence s_latch;
        o_addr_latch_strobe [*2] ##1 !o_addr_latch_strobe;
    endsequence
    a_latch_once : assert property (@(posedge i_core_clk) disable iff (i_rst || soft_rst)
        $rose(in_addr) |-> s_latch ##1 !o_addr_latch_strobe [*2])
        else $error("latch strobe not one pulse");
    a_latch_addr : assert property (@(posedge i_core_clk) disable iff (i_rst)
        $fell(o_addr_latch_strobe) |-> o_addr_data_oe == 8'hFF)
        else $error("address not driven at latch fall");
    a_strobe_mc : assert property (@(posedge i_core_clk) disable iff (i_rst || soft_rst)
        $rose(in_strb) |-> in_strb [*4])
        else $error("strobe shorter than a machine cycle");
    a_addr_hold : assert property (@(posedge i_core_clk) disable iff (i_rst)
        (in_strb && $past(in_strb)) |-> $stable(o_addr_high))
        else $error("address moved under strobe");
    a_reset_hold : assert property (@(posedge i_core_clk) disable iff (i_rst)
        $rose(o_reset) |-> $past(rst_sync[1], 7))
        else $error("reset without long enough pin");
    a_addr_phase : assert property (@(posedge i_core_clk) disable iff (i_rst || soft_rst)
        $rose(in_addr) |-> (phase == 2'h0))
        else $error("address cycle not aligned to machine cycle");
    a_strobe_excl : assert property (@(posedge i_core_clk) disable iff (i_rst)
        !(!o_data_read_strobe_n && !o_data_write_strobe_n))
        else $error("read and write strobes active together");
endmodule

// File: pkg/xbus_pkg.sv
// Constants and types for the external memory bus interface
// Function
// - Machine cycle is four clocks; all strobes sequenced in machine cycles.
// - Reset pin held high two machine cycles while clock runs resets device. Here o_reset rises once the synchronised pin has stayed high seven clocks.
// - Fetch-force pin low sends every program fetch to external memory.
// - Pin high and PC inside 128 KB keeps fetches off the bus.
// - Program-read strobe asserted for external fetches and table reads; memory drives data.
// - No program-read strobe pulse for accesses served internally.
// - Address-latch strobe lets an external latch capture the low address byte.
// - Low port multiplexes address and data; otherwise open-drain general port.
// - Upper eight address bits appear on second port during external accesses.
// - Data-write strobe on port 3 bit 6, data-read strobe on bit 7.
// - Software sets data-move access length from two to nine machine cycles.
// - On-chip 1 KB data SRAM at 0000H-03FFH, data moves only, software enabled.
// - Software may enable low port internal pull-ups.
// - Port 4 bit 3 alternate function reboots from the loader bank.
// - With SRAM enabled, data moves above 03FFH still go external.
// - SRAM enable cleared at reset; all data moves go external. Here i_onchip_xram_enable is an input that reset does not clear.
package xbus_pkg;
    localparam int unsigned CLK_PER_MC      = 4;
    localparam logic [1:0]  PHASE_LAST      = 2'h3;
    localparam logic [2:0]  RST_HOLD_CLKS   = 3'h7;
    localparam logic [3:0]  STRETCH_MIN     = 4'h2;
    localparam logic [3:0]  STRETCH_MAX     = 4'h9;
    localparam logic [15:0] XRAM_TOP        = 16'h03FF;
    localparam logic [16:0] INT_CODE_TOP    = 17'h1FFFF;
    localparam int unsigned XRAM_DEPTH      = 1024;

    typedef enum logic [3:0]
    {
        BUS_FETCH = 4'h0,
        BUS_TABLE = 4'h1,
        BUS_READ  = 4'h2,
        BUS_WRITE = 4'h3
    } bus_op_t;

    typedef enum logic [4:0]
    {
        ST_IDLE  = 5'h01,
        ST_ADDR  = 5'h02,
        ST_STRB  = 5'h04,
        ST_HOLD  = 5'h08,
        ST_DONE  = 5'h10
    } bus_state_t;
endpackage

// File: verification/xbus_memory_model.sv
// Behavioural external memory sitting on the multiplexed low port and upper address port
`timescale 1ns/1ps
module xbus_memory_model
(
    // Device bus pins
    input  wire logic       i_core_clk,
    input  wire logic [7:0] i_ad,
    input  wire logic [7:0] i_ad_oe,
    input  wire logic       i_pullup,
    input  wire logic [7:0] i_high,
    input  wire logic       i_ale,
    input  wire logic       i_prog_n,
    input  wire logic       i_rd_n,
    input  wire logic       i_wr_n,
    // Resolved port level and latched address
    output logic [7:0]      o_pin,
    output logic [15:0]     o_latched
);
    logic [7:0] mem [logic [15:0]];
    logic [7:0] last_pin = 8'h00;
    logic [7:0] other;
    initial o_latched = 16'h0000;
    // Unwritten places answer low ^ high; a released line reads high with pull-ups on, else the inverse of its last level
    always @*
    begin
        if (!i_prog_n || !i_rd_n)
            other = mem.exists(o_latched) ? mem[o_latched] : o_latched[7:0] ^ o_latched[15:8];
        else
            other = i_pullup ? 8'hFF : ~last_pin;
        o_pin = (i_ad_oe & i_ad) | (~i_ad_oe & other);
    end
    always @(posedge i_core_clk)
    begin
        last_pin <= (!i_prog_n || !i_rd_n) ? o_pin : ((i_ad_oe & o_pin) | (~i_ad_oe & last_pin));
        if (i_ale)
            o_latched <= {i_high, o_pin};
        if (!i_wr_n)
            mem[o_latched] = o_pin;
    end
endmodule

// File: verification/external_memory_bus_interface_bench.sv
// Self-checking bench for the external memory bus interface
`timescale 1ns/1ps
module external_memory_bus_interface_bench;
    logic        i_core_clk, i_rst, i_reset_pin, i_external_fetch_force_n, i_reboot_pin;
    logic        i_req, i_onchip_xram_enable, i_pullup_enable;
    logic [7:0]  i_addr_data, i_wdata, i_port0_out, o_rdata, o_addr_data, o_addr_data_oe;
    logic [7:0]  o_addr_high, high_seen;
    logic [3:0]  i_op, i_stretch_mc;
    logic [16:0] i_addr;
    logic [15:0] latched;
    logic        o_busy, o_done, o_internal_code, o_reset, o_reboot, o_pullup_enable;
    logic        o_addr_latch_strobe, o_program_read_strobe_n;
    logic        o_data_read_strobe_n, o_data_write_strobe_n;
    int          miscompares, samples_checked, ale_count, strb_cycles, n, e;
    logic [3:0]  mcs [5] = '{4'h1, 4'h2, 4'h5, 4'h9, 4'hF};
    external_memory_bus_interface u_external_memory_bus_interface
    (
        .i_core_clk               (i_core_clk),
        .i_rst                    (i_rst),
        .i_reset_pin              (i_reset_pin),
        .i_external_fetch_force_n (i_external_fetch_force_n),
        .i_reboot_pin             (i_reboot_pin),
        .i_addr_data              (i_addr_data),
        .i_req                    (i_req),
        .i_op                     (i_op),
        .i_addr                   (i_addr),
        .i_wdata                  (i_wdata),
        .i_stretch_mc             (i_stretch_mc),
        .i_onchip_xram_enable     (i_onchip_xram_enable),
        .i_pullup_enable          (i_pullup_enable),
        .i_port0_out              (i_port0_out),
        .o_busy                   (o_busy),
        .o_done                   (o_done),
        .o_rdata                  (o_rdata),
        .o_internal_code          (o_internal_code),
        .o_reset                  (o_reset),
        .o_reboot                 (o_reboot),
        .o_addr_data              (o_addr_data),
        .o_addr_data_oe           (o_addr_data_oe),
        .o_pullup_enable          (o_pullup_enable),
        .o_addr_high              (o_addr_high),
        .o_addr_latch_strobe      (o_addr_latch_strobe),
        .o_program_read_strobe_n  (o_program_read_strobe_n),
        .o_data_read_strobe_n     (o_data_read_strobe_n),
        .o_data_write_strobe_n    (o_data_write_strobe_n)
    );
    xbus_memory_model u_xbus_memory_model
    (
        .i_core_clk (i_core_clk),
        .i_ad       (o_addr_data),
        .i_ad_oe    (o_addr_data_oe),
        .i_pullup   (o_pullup_enable),
        .i_high     (o_addr_high),
        .i_ale      (o_addr_latch_strobe),
        .i_prog_n   (o_program_read_strobe_n),
        .i_rd_n     (o_data_read_strobe_n),
        .i_wr_n     (o_data_write_strobe_n),
        .o_pin      (i_addr_data),
        .o_latched  (latched)
    );
    initial
    begin
        i_core_clk = 1'b0;
        forever #2.5 i_core_clk = ~i_core_clk;
    end
    task automatic end_sim();
        if (miscompares == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", name, exp, got);
        end
    endtask
    task automatic wait_reset(input logic lvl);
        for (n = 0; n < 40 && o_reset !== lvl; n++)
            @(posedge i_core_clk);
        check("o_reset", lvl, o_reset);
    endtask
    // Request is held until done is sampled high at a falling edge and dropped at the next rising edge
    task automatic access(input logic [3:0] op, input logic [16:0] a, input logic [7:0] wd,
                          input logic [3:0] mc);
        logic prev;
        logic done;
        int   k;
        prev = 1'b0;
        done = 1'b0;
        ale_count = 0;
        strb_cycles = 0;
        @(posedge i_core_clk);
        i_req <= 1'b1;
        i_op <= op;
        i_addr <= a;
        i_wdata <= wd;
        i_stretch_mc <= mc;
        for (k = 0; k < 100 && !done; k++)
        begin
            @(negedge i_core_clk);
            ale_count += (o_addr_latch_strobe && !prev);
            prev = o_addr_latch_strobe;
            if (!(o_program_read_strobe_n && o_data_read_strobe_n && o_data_write_strobe_n))
            begin
                strb_cycles++;
                high_seen = o_addr_high;
            end
            done = (o_done === 1'b1);
        end
        if (!done)
        begin
            miscompares++;
            end_sim();
        end
        @(posedge i_core_clk);
        i_req <= 1'b0;
    endtask
    initial
    begin
        {i_rst, i_reset_pin, i_reboot_pin, i_req, i_onchip_xram_enable, i_pullup_enable} = 6'h20;
        {i_op, i_addr, i_wdata, i_stretch_mc} = '0;
        i_external_fetch_force_n = 1'b1;
        i_port0_out = 8'h5A;
        repeat (3) @(posedge i_core_clk);
        i_rst <= 1'b0;
        @(negedge i_core_clk);
        check("idle_oe", 8'hA5, o_addr_data_oe);
        @(posedge i_core_clk);
        i_reset_pin <= 1'b1;
        @(posedge i_core_clk);
        i_reset_pin <= 1'b0;
        repeat (12) @(posedge i_core_clk);
        check("short_reset", 1'b0, o_reset);
        i_reset_pin <= 1'b1;
        wait_reset(1'b1);
        check("reset_hold", 1'b1, n >= 8);
        i_reset_pin <= 1'b0;
        wait_reset(1'b0);
        for (int i = 0; i < 5; i++)
        begin
            e = mcs[i] < 2 ? 2 : (mcs[i] > 9 ? 9 : mcs[i]);
            access(4'h3, 17'h1200 + i, 8'hC0 + i, mcs[i]);
            check("wr_len", (e - 1) * 4, strb_cycles);
            check("wr_ale", 1, ale_count);
            check("wr_high", 8'h12, high_seen);
            check("latched", 16'h1200 + i, latched);
            access(4'h2, 17'h1200 + i, 8'h00, mcs[i]);
            check("rd_len", (e - 1) * 4, strb_cycles);
            check("rd_data", 8'hC0 + i, o_rdata);
        end
        access(4'h2, 17'h0010, 8'h00, 4'h2);
        check("off_ale", 1, ale_count);
        check("off_data", 8'h10, o_rdata);
        i_onchip_xram_enable <= 1'b1;
        access(4'h3, 17'h03FF, 8'h3C, 4'h2);
        check("on_wr_ale", 0, ale_count);
        access(4'h2, 17'h03FF, 8'h00, 4'h2);
        check("on_rd_ale", 0, ale_count);
        check("on_data", 8'h3C, o_rdata);
        access(4'h2, 17'h0400, 8'h00, 4'h2);
        check("above_ale", 1, ale_count);
        check("above_data", 8'h04, o_rdata);
        i_external_fetch_force_n <= 1'b0;
        repeat (4) @(posedge i_core_clk);
        access(4'h0, 17'h00456, 8'h00, 4'h2);
        check("ext_fetch", 4, strb_cycles);
        check("fetch_data", 8'h52, o_rdata);
        check("ext_code", 1'b0, o_internal_code);
        access(4'h1, 17'h00789, 8'h00, 4'h2);
        check("table_data", 8'h8E, o_rdata);
        i_external_fetch_force_n <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        access(4'h0, 17'h00456, 8'h00, 4'h2);
        check("int_strobe", 0, strb_cycles + ale_count);
        check("int_code", 1'b1, o_internal_code);
        i_pullup_enable <= 1'b1;
        i_reboot_pin <= 1'b1;
        repeat (4) @(posedge i_core_clk);
        check("pullup", 1'b1, o_pullup_enable);
        check("reboot", 1'b1, o_reboot);
        check("idle_busy", 1'b0, o_busy);
        end_sim();
    end
endmodule
